// ===== logic/lt_timer.sv
// Hardware limit timer with APB registers, prescaler, postscaler and clear sources
// Summary of operation
// RULE1: Counter runs from instruction clock, a quarter of the input clock rate.
// RULE2: Prescale select 00,01,10,11 divides by 1, 4, 16, 64.
// RULE3: Counter equal to period gives match; counter clears on next tick.
// RULE4: Count and period readable, writable; reset gives count 00, period FF.
// RULE5: Count write, control 0 write and reset clear pre and postscaler.
// RULE6: Control 0 write leaves the counter value alone.
// RULE7: Matches advance 4-bit postscaler; its overflow sets the match flag.
// RULE8: Interrupt request only when match flag and its enable are set.
// RULE9: Postscale select code n gives one flag per n+1 matches.
// RULE10: Control 0 bit 2 turns the timer on or off.
// RULE11: Control 0 bit 7 is unimplemented and reads zero.
// RULE12: Control 1 selects one external clear source.
// RULE13: Codes 0-5 pick CCP, cmp1, cmp2, fault, out0, out1; 6,7 zero.
// RULE14: Separate rise and fall enables; disabled polarity has no effect.
// RULE15: Per polarity, sensitivity bit set means edge, clear means level.
// RULE16: Enabled clear event clears counter on next timer tick.
// RULE17: Count write beats a coincident clear and discards pending clears.
// RULE18: Unscaled match output goes only to the output generator.
// RULE19: While asleep the timer does not count and holds its value.
// RULE20: While off, counter and scalers hold; no match or flag.
// RULE21: Level mode holds counter at zero while source stays at level.
//
// The APB slave port and the register offsets were left to the implementer.
`default_nettype none
module lt_timer
  import lt_pkg::*;
(
  input wire logic pclk, // System clock, 50 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic sleep, // Processor sleep, same clock domain
  input wire logic ccp_out, // Capture/compare output
  input wire logic cmp1_out, // Comparator 1 output
  input wire logic cmp2_out, // Comparator 2 output
  input wire logic cog_fault_pin, // Generator fault pin
  input wire logic cog_output_0, // Generator output 0
  input wire logic cog_output_1, // Generator output 1
  output logic limit_match_output, // Unscaled match to output generator
  output logic match_irq // Interrupt request
);
  logic [7:0] limit_count_reg;
  logic [7:0] limit_period_reg;
  logic [7:0] limit_control_0;
  logic [7:0] limit_control_1;
  logic match_irq_flag;
  logic match_irq_enable;
  logic [1:0] instr_div;
  logic instr_tick;
  logic [5:0] pre_cnt;
  logic [3:0] post_cnt;
  logic timer_tick;
  logic [5:0] src_sync;
  logic src_now;
  logic src_prev;
  logic src_rise;
  logic src_fall;
  logic sel_settle;
  logic rise_pend;
  logic fall_pend;
  logic clear_now;
  logic match;
  logic [5:0] pre_last;
  logic wr_acc;
  logic rd_setup;
  logic addr_ok;
  logic wr_count;
  logic wr_period;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_flag;
  logic wr_enable;
  logic [7:0] next_rdata;

  // APB decode: zero wait states
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign addr_ok = (paddr == LT_OFF_COUNT) || (paddr == LT_OFF_PERIOD)
    || (paddr == LT_OFF_CTRL0) || (paddr == LT_OFF_CTRL1)
    || (paddr == LT_OFF_FLAG) || (paddr == LT_OFF_ENABLE);
  assign wr_count = wr_acc && (paddr == LT_OFF_COUNT);
  assign wr_period = wr_acc && (paddr == LT_OFF_PERIOD);
  assign wr_ctrl0 = wr_acc && (paddr == LT_OFF_CTRL0);
  assign wr_ctrl1 = wr_acc && (paddr == LT_OFF_CTRL1);
  assign wr_flag = wr_acc && (paddr == LT_OFF_FLAG);
  assign wr_enable = wr_acc && (paddr == LT_OFF_ENABLE);

  // Instruction clock enable, one in four
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1; // RULE1
    end
  end
  assign instr_tick = (instr_div == LT_INSTR_LAST);

  // Prescaler terminal value per select code
  always_comb begin
    case (limit_control_0[LT_C0_PRE_LO +: 2])
      2'h0: pre_last = 6'h00; // RULE2
      2'h1: pre_last = 6'h03;
      2'h2: pre_last = 6'h0F;
      2'h3: pre_last = 6'h3F;
      default: pre_last = 6'h00;
    endcase
  end

  // Timer tick gated by on bit and sleep
  assign timer_tick = instr_tick && limit_control_0[LT_C0_ON] && !sleep // RULE10 RULE19 RULE20
    && (pre_cnt == pre_last);

  // Prescaler counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 6'h00;
    end else if (wr_count || wr_ctrl0) begin
      pre_cnt <= 6'h00; // RULE5
    end else if (instr_tick && limit_control_0[LT_C0_ON] && !sleep) begin
      pre_cnt <= (pre_cnt == pre_last) ? 6'h00 : pre_cnt + 6'h01;
    end
  end

  // Clear source synchronisers
  lt_sync #(.WIDTH(6)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({cog_output_1, cog_output_0, cog_fault_pin, cmp2_out, cmp1_out, ccp_out}),
    .q(src_sync)
  );

  // Clear source multiplexer
  always_comb begin
    case (limit_control_1[LT_C1_SRC_LO +: 3])
      LT_SRC_CCP: src_now = src_sync[0]; // RULE12 RULE13
      LT_SRC_CMP1: src_now = src_sync[1];
      LT_SRC_CMP2: src_now = src_sync[2];
      LT_SRC_FLT: src_now = src_sync[3];
      LT_SRC_OUT0: src_now = src_sync[4];
      LT_SRC_OUT1: src_now = src_sync[5];
      default: src_now = 1'b0;
    endcase
  end

  // Previous source level for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_now;
    end
  end

  // Cycle after a source select change, when the detector compares two lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_settle <= 1'b0;
    end else begin
      sel_settle <= wr_ctrl1;
    end
  end

  // Source edges, masked while the select settles to avoid a false clear
  assign src_rise = src_now && !src_prev && !sel_settle;
  assign src_fall = !src_now && src_prev && !sel_settle;

  // Pending rising event, cleared on tick or by count write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_pend <= 1'b0;
    end else if (wr_count) begin
      rise_pend <= 1'b0; // RULE17
    end else if (src_rise && limit_control_1[LT_C1_REN]) begin
      rise_pend <= 1'b1; // RULE14 RULE15
    end else if (timer_tick) begin
      rise_pend <= 1'b0;
    end
  end

  // Pending falling event, cleared on tick or by count write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_pend <= 1'b0;
    end else if (wr_count) begin
      fall_pend <= 1'b0; // RULE17
    end else if (src_fall && limit_control_1[LT_C1_FEN]) begin
      fall_pend <= 1'b1; // RULE14 RULE15
    end else if (timer_tick) begin
      fall_pend <= 1'b0;
    end
  end

  // Clear condition from edge pendings or held levels
  assign clear_now =
    (limit_control_1[LT_C1_REN] && (limit_control_1[LT_C1_RES] ? rise_pend : src_now))
    || (limit_control_1[LT_C1_FEN] && (limit_control_1[LT_C1_FES] ? fall_pend : !src_now)); // RULE21

  // Period compare, blocked by a clear on this tick
  assign match = (limit_count_reg == limit_period_reg) && !clear_now; // RULE3

  // Main counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_count_reg <= LT_COUNT_RST; // RULE4
    end else if (wr_count) begin
      limit_count_reg <= pwdata[7:0]; // RULE17
    end else if (timer_tick) begin
      if (clear_now || match) begin
        limit_count_reg <= 8'h00; // RULE16 RULE3
      end else begin
        limit_count_reg <= limit_count_reg + 8'h01; // RULE1
      end
    end
  end

  // Unscaled match pulse to the output generator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_match_output <= 1'b0;
    end else begin
      limit_match_output <= timer_tick && match && !wr_count; // RULE18
    end
  end

  // Postscaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_cnt <= 4'h0;
    end else if (wr_count || wr_ctrl0) begin
      post_cnt <= 4'h0; // RULE5
    end else if (timer_tick && match) begin
      if (post_cnt == limit_control_0[LT_C0_POST_LO +: 4]) begin
        post_cnt <= 4'h0; // RULE9
      end else begin
        post_cnt <= post_cnt + 4'h1; // RULE7
      end
    end
  end

  // Match flag: hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_irq_flag <= 1'b0;
    end else if (timer_tick && match && !wr_count && !wr_ctrl0
      && post_cnt == limit_control_0[LT_C0_POST_LO +: 4]) begin
      match_irq_flag <= 1'b1; // RULE7
    end else if (wr_flag) begin
      match_irq_flag <= pwdata[0];
    end
  end

  // Interrupt request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_irq <= 1'b0;
    end else begin
      match_irq <= match_irq_flag && match_irq_enable; // RULE8
    end
  end

  // Period register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_period_reg <= LT_PERIOD_RST; // RULE4
    end else if (wr_period) begin
      limit_period_reg <= pwdata[7:0];
    end
  end

  // Control register 0, top bit kept at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_control_0 <= LT_CTRL0_RST;
    end else if (wr_ctrl0) begin
      limit_control_0 <= pwdata[7:0] & LT_C0_MASK; // RULE11 RULE6
    end
  end

  // Control register 1, bit 5 kept at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_control_1 <= LT_CTRL1_RST;
    end else if (wr_ctrl1) begin
      limit_control_1 <= pwdata[7:0] & LT_C1_MASK;
    end
  end

  // Interrupt enable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_irq_enable <= 1'b0;
    end else if (wr_enable) begin
      match_irq_enable <= pwdata[0];
    end
  end

  // Read multiplexer
  always_comb begin
    case (paddr)
      LT_OFF_COUNT: next_rdata = limit_count_reg;
      LT_OFF_PERIOD: next_rdata = limit_period_reg;
      LT_OFF_CTRL0: next_rdata = limit_control_0; // RULE11
      LT_OFF_CTRL1: next_rdata = limit_control_1;
      LT_OFF_FLAG: next_rdata = {7'h00, match_irq_flag};
      LT_OFF_ENABLE: next_rdata = {7'h00, match_irq_enable};
      default: next_rdata = 8'h00;
    endcase
  end

  // Ready, high for the single access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // Error, beside ready for an unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // Read data taken in the setup cycle, held until the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= {24'h000000, next_rdata};
    end
  end
endmodule : lt_timer
`default_nettype wire

// ===== logic/lt_pkg.sv
// Package of register map, field positions and reset values for the limit timer
`default_nettype none
package lt_pkg;
  // Register byte offsets on the APB
  localparam logic [7:0] LT_OFF_COUNT = 8'h00;
  localparam logic [7:0] LT_OFF_PERIOD = 8'h04;
  localparam logic [7:0] LT_OFF_CTRL0 = 8'h08;
  localparam logic [7:0] LT_OFF_CTRL1 = 8'h0C;
  localparam logic [7:0] LT_OFF_FLAG = 8'h10;
  localparam logic [7:0] LT_OFF_ENABLE = 8'h14;
  // Reset values
  localparam logic [7:0] LT_COUNT_RST = 8'h00;
  localparam logic [7:0] LT_PERIOD_RST = 8'hFF;
  localparam logic [7:0] LT_CTRL0_RST = 8'h00;
  localparam logic [7:0] LT_CTRL1_RST = 8'h00;
  // Control 0 fields
  localparam int LT_C0_PRE_LO = 0;
  localparam int LT_C0_ON = 2;
  localparam int LT_C0_POST_LO = 3;
  localparam logic [7:0] LT_C0_MASK = 8'h7F;
  // Control 1 fields
  localparam int LT_C1_REN = 0;
  localparam int LT_C1_FEN = 1;
  localparam int LT_C1_SRC_LO = 2;
  localparam int LT_C1_RES = 6;
  localparam int LT_C1_FES = 7;
  localparam logic [7:0] LT_C1_MASK = 8'hDF;
  // Clear source codes
  localparam logic [2:0] LT_SRC_CCP = 3'h0;
  localparam logic [2:0] LT_SRC_CMP1 = 3'h1;
  localparam logic [2:0] LT_SRC_CMP2 = 3'h2;
  localparam logic [2:0] LT_SRC_FLT = 3'h3;
  localparam logic [2:0] LT_SRC_OUT0 = 3'h4;
  localparam logic [2:0] LT_SRC_OUT1 = 3'h5;
  // Instruction clock: one enable per four system clocks
  localparam int LT_INSTR_DIV = 4;
  localparam logic [1:0] LT_INSTR_LAST = 2'h3;
endpackage : lt_pkg
`default_nettype wire

// ===== logic/lt_sync.sv
// Two-flop synchroniser for a bundle of asynchronous inputs
`default_nettype none
module lt_sync #(
  parameter int WIDTH = 6
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic [WIDTH-1:0] d, // Asynchronous inputs
  output logic [WIDTH-1:0] q // Synchronised outputs
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds the second only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      q <= '0;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule : lt_sync
`default_nettype wire

// ===== verif/lt_src_model.sv
// Model of the peripheral lines that can clear the limit timer
`default_nettype none
module lt_src_model (
  input wire logic pclk, // Clock
  input wire logic [2:0] sel, // Line driven on purpose
  input wire logic lvl, // Level for that line
  output var logic [5:0] src // Source lines
);
  timeunit 1ns;
  timeprecision 100ps;
  // Chosen line follows lvl, the others chatter every cycle
  always @(posedge pclk) begin
    for (int i = 0; i < 6; i++) begin
      src[i] <= (i == int'(sel)) ? lvl : 1'($urandom);
    end
  end
endmodule : lt_src_model
`default_nettype wire

// ===== verif/lt_timer_props.sv
// Port checker for the limit timer
`default_nettype none
module lt_timer_props
  import lt_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic sleep, // Sleep
  input wire logic limit_match_output, // Match pulse
  input wire logic match_irq // Interrupt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic mapped;
  // Decode of the six registers
  assign mapped = paddr inside {LT_OFF_COUNT, LT_OFF_PERIOD, LT_OFF_CTRL0,
    LT_OFF_CTRL1, LT_OFF_FLAG, LT_OFF_ENABLE};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answers
  chk_ready_access: assert property (psel && !penable |=> pready && penable)
    else $error("No ready in access");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("Ready too long");
  chk_map_err: assert property (pready |-> pslverr == !mapped)
    else $error("Bad error flag");
  chk_bad_rdata: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("Unmapped read not zero");
  chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("Upper read bits set");
  chk_ctrl0_top: assert property (pready && !pwrite && paddr == LT_OFF_CTRL0 |-> !prdata[7])
    else $error("Control bit 7 set");
  // Timer outputs
  chk_match_gap: assert property (limit_match_output |=> !limit_match_output [*3])
    else $error("Match pulses too close");
  chk_sleep_quiet: assert property (sleep ##1 sleep |-> !limit_match_output)
    else $error("Match while asleep");
  cover property (limit_match_output);
  cover property ($rose(match_irq));
  cover property (pready && pslverr);
endmodule : lt_timer_props
bind lt_timer lt_timer_props i_lt_timer_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .sleep, .limit_match_output, .match_irq);
`default_nettype wire

// ===== verif/tb.sv
// Bench for the limit timer
`default_nettype none
module tb import lt_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic sleep, lvl, lmo, irq, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [5:0] src;
  logic [2:0] sel;
  int n_mismatch, n_compared, n_match, g, p, post, e;
  logic [7:0] mb [5] = '{8'h01, 8'h41, 8'h82, 8'h82, 8'h02};
  logic l0 [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  int ex [5] = '{2, 1, 1, 0, 2};
  lt_timer i_lt_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sleep, .ccp_out(src[0]), .cmp1_out(src[1]),
    .cmp2_out(src[2]), .cog_fault_pin(src[3]), .cog_output_0(src[4]),
    .cog_output_1(src[5]), .limit_match_output(lmo), .match_irq(irq));
  lt_src_model i_lt_src_model (.pclk, .sel, .lvl, .src);
  // Clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Match pulse counter
  always @(posedge pclk) begin
    if (lmo === 1'b1) n_match <= n_match + 1;
  end
  function automatic int exp_gap(int ps, int per);
    return 4 * (1 << (2 * ps)) * (per + 1);
  endfunction : exp_gap
  function automatic int cls(logic [7:0] c);
    return (c === 8'h00) ? 2 : (c < 8'h40) ? 1 : 0;
  endfunction : cls
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Cycles between two match pulses
  task automatic gap(output int n);
    while (lmo !== 1'b1) @(posedge pclk);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (lmo !== 1'b1);
  endtask : gap
  // Arm a clear mode, preload the count, move the chosen line
  task automatic clr(input logic [2:0] s, input int m);
    sel <= s;
    lvl <= l0[m];
    cyc(4);
    apb(1'b1, LT_OFF_CTRL1, mb[m] | {3'h0, s, 2'h0});
    apb(1'b1, LT_OFF_COUNT, 8'h80);
    lvl <= !l0[m];
    cyc(24);
    apb(1'b0, LT_OFF_COUNT, 8'h00);
  endtask : clr
  task automatic end_sim();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  // Watchdog
  initial begin
    #1000000;
    $display("Error at %0t: watchdog expired", $time);
    n_mismatch++;
    end_sim();
  end
  initial begin
    {presetn, psel, penable, pwrite, sleep, lvl} = 6'h00;
    {paddr, pwdata, sel} = 43'h0;
    void'($urandom(32'hBC0A));
    cyc(5);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, unmapped slot, control 0 top bit
    apb(1'b0, LT_OFF_COUNT, 8'h00);
    chk(rv, 32'h00);
    apb(1'b0, LT_OFF_PERIOD, 8'h00);
    chk(rv, 32'hFF);
    apb(1'b0, 8'h18, 8'h00);
    chk(perr, 1'b1);
    apb(1'b1, LT_OFF_CTRL0, 8'hFF);
    apb(1'b0, LT_OFF_CTRL0, 8'h00);
    chk(rv, 32'h7F);
    // Prescale codes and period match
    for (int ps = 0; ps < 4; ps++) begin
      p = $urandom_range(1, 6);
      apb(1'b1, LT_OFF_CTRL0, 8'h00);
      apb(1'b1, LT_OFF_COUNT, 8'h00);
      apb(1'b1, LT_OFF_PERIOD, 8'(p));
      apb(1'b1, LT_OFF_CTRL0, 8'h04 | 8'(ps));
      gap(g);
      chk(g, exp_gap(ps, p));
    end
    // Postscale ratios, extremes and a random one
    apb(1'b1, LT_OFF_ENABLE, 8'h01);
    for (int i = 0; i < 3; i++) begin
      post = (i == 0) ? 0 : (i == 1) ? 15 : $urandom_range(1, 14);
      apb(1'b1, LT_OFF_CTRL0, 8'h00);
      apb(1'b1, LT_OFF_COUNT, 8'h00);
      apb(1'b1, LT_OFF_PERIOD, 8'h00);
      apb(1'b1, LT_OFF_FLAG, 8'h00);
      g = n_match;
      apb(1'b1, LT_OFF_CTRL0, 8'h04 | 8'(post << 3));
      while (irq !== 1'b1) @(posedge pclk);
      chk(n_match - g, post + 1);
    end
    // Interrupt gating by its enable
    apb(1'b1, LT_OFF_CTRL0, 8'h00);
    apb(1'b1, LT_OFF_ENABLE, 8'h00);
    cyc(2);
    chk(irq, 1'b0);
    apb(1'b1, LT_OFF_ENABLE, 8'h01);
    cyc(2);
    chk(irq, 1'b1);
    apb(1'b1, LT_OFF_FLAG, 8'h00);
    cyc(2);
    chk(irq, 1'b0);
    // Timer off holds count, no match even at period
    apb(1'b1, LT_OFF_PERIOD, 8'h5A);
    apb(1'b1, LT_OFF_COUNT, 8'h5A);
    g = n_match;
    cyc(100);
    apb(1'b0, LT_OFF_COUNT, 8'h00);
    chk(rv, 32'h5A);
    chk(n_match - g, 0);
    apb(1'b1, LT_OFF_CTRL0, 8'h78);
    apb(1'b0, LT_OFF_COUNT, 8'h00);
    chk(rv, 32'h5A);
    // Sleep freezes the count, waking resumes it
    apb(1'b1, LT_OFF_CTRL0, 8'h04);
    apb(1'b1, LT_OFF_PERIOD, 8'hFF);
    sleep <= 1'b1;
    cyc(2);
    apb(1'b1, LT_OFF_COUNT, 8'h10);
    cyc(200);
    apb(1'b0, LT_OFF_COUNT, 8'h00);
    chk(rv, 32'h10);
    sleep <= 1'b0;
    cyc(40);
    apb(1'b0, LT_OFF_COUNT, 8'h00);
    chk(rv[7:0] > 8'h10, 1'b1);
    // Every source code in each clear mode
    for (int s = 0; s < 8; s++) begin
      for (int m = 0; m < 5; m++) begin
        clr(3'(s), m);
        e = (s > 5) ? ((m == 4) ? 2 : 0) : ex[m];
        chk(cls(rv[7:0]), e);
      end
    end
    // Count write discards a clear left pending while off
    apb(1'b1, LT_OFF_CTRL0, 8'h00);
    clr(3'h0, 1);
    chk(rv, 32'h80);
    apb(1'b1, LT_OFF_COUNT, 8'h50);
    apb(1'b1, LT_OFF_CTRL0, 8'h04);
    cyc(24);
    apb(1'b0, LT_OFF_COUNT, 8'h00);
    chk(cls(rv[7:0]), 0);
    end_sim();
  end
endmodule : tb
`default_nettype wire
